// file: hdl/rts_pkg.sv
// constants, types and state layout of the reset time-out sequencer
package rts_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses on the avalon slave)
  // ---------------------------------------------------------------
  localparam logic [3:0] RTS_OFS_CONFIG = 4'h0;
  localparam logic [3:0] RTS_OFS_STATUS = 4'h4;
  localparam logic [3:0] RTS_OFS_KEEP = 4'h8;

  // config fields
  localparam int RTS_CFG_OSC_LSB = 0;
  localparam int RTS_CFG_EXT_BIT = 2;
  // status fields
  localparam int RTS_ST_TO_BIT = 0;
  localparam int RTS_ST_PD_BIT = 1;
  localparam int RTS_ST_UPPER_LSB = 2;
  localparam int RTS_ST_RESET_BIT = 4;
  localparam int RTS_ST_PHASE_LSB = 5;
  localparam int RTS_ST_SEEN_BIT = 7;

  // ---------------------------------------------------------------
  // oscillator modes
  // ---------------------------------------------------------------
  localparam logic [1:0] RTS_OSC_LF = 2'h0;
  localparam logic [1:0] RTS_OSC_XT = 2'h1;
  localparam logic [1:0] RTS_OSC_EC = 2'h2;
  localparam logic [1:0] RTS_OSC_RC = 2'h3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] RTS_RST_OSC_MODE = RTS_OSC_XT;
  localparam logic [1:0] RTS_UPPER_RESET = 2'h3;
  localparam logic [1:0] RTS_UPPER_WAKE_EN = 2'h2;
  localparam logic [31:0] RTS_RDATA_IDLE = 32'h0000_0000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int RTS_SETTLE_MS = 96;
  localparam int RTS_RC_TICK_KHZ = 32;
  localparam int RTS_SETTLE_TICKS = RTS_SETTLE_MS * RTS_RC_TICK_KHZ;
  localparam int RTS_SETTLE_W = 16;
  localparam int RTS_OST_CYCLES = 1024;
  localparam int RTS_OST_W = 11;

  // synchroniser bit positions
  localparam int RTS_SY_POR = 0;
  localparam int RTS_SY_MASTER_CLEAR_PIN = 1;
  localparam int RTS_SY_OSC = 2;
  localparam int RTS_SY_OVALID = 3;
  localparam int RTS_SY_RC = 4;
  localparam int RTS_SY_WDT = 5;
  localparam int RTS_SY_N = 6;

  typedef enum logic [2:0] {
    SEQ_POR,
    SEQ_SETTLE,
    SEQ_RUN,
    SEQ_MASTER_CLEAR_PIN,
    SEQ_OSC_WAIT,
    SEQ_WAKE
  } rts_seq_t;

  typedef struct packed {
    logic [RTS_SY_N-1:0] sync1;
    logic [RTS_SY_N-1:0] sync2;
    logic [RTS_SY_N-1:0] sync3;
    rts_seq_t seq;
    logic supply_seen;
    logic ost_needed;
    logic [RTS_SETTLE_W-1:0] rc_cnt;
    logic [RTS_OST_W-1:0] osc_cnt;
    logic core_reset;
    logic [1:0] phase;
    logic addr_latch_strobe;
    logic read_strobe_n;
    logic write_strobe_n;
    logic strobe_oe_n;
    logic timeout_flag_n;
    logic powerdown_flag_n;
    logic [1:0] status_upper;
    logic regs_init;
    logic pc_load_zero;
    logic pc_advance;
    logic vector_fetch;
    logic wake_resume;
    logic [1:0] osc_mode;
    logic ext_exec;
    logic [7:0] keep_reg;
    logic waitrequest;
    logic [31:0] readdata;
  } rts_state_t;

endpackage

// file: hdl/rts_sequencer.sv
// reset source tracking, settle timers and core reset release
//
// Overview of operation
// - tell supply, master-clear, watchdog resets and sleep apart
// - init registers except on watchdog reset in sleep
// - keep register untouched by every device reset
// - hold phase at phase one during reset
// - in reset drive strobes: latch low, read/write high
// - stay in reset while supply detect inactive
// - supply fall resets, except legacy variant
// - supply timer starts after supply up, clear high
// - RC-clocked supply timer holds reset while counting
// - oscillator counter waits 1024 oscillator periods
// - oscillator delay only in crystal modes
// - count oscillator pulses only once amplitude valid
// - start both timers, release when both expire
// - normal master-clear reset adds no settle time
// - oscillator counter only for supply-up, sleep resets and wake
// - set timeout and powerdown flags per event
// - every reset loads program counter with zero
// - wake advances program counter, maybe vectors
//
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none

module rts_sequencer
  import rts_pkg::*;
#(
  parameter int SETTLE_TICKS = RTS_SETTLE_TICKS,
  parameter bit LEGACY_VARIANT = 1'b0
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // asynchronous pins and detectors
  input wire logic supply_up_detect,
  input wire logic master_clear_pin,
  input wire logic osc_input_pin,
  input wire logic osc_valid,
  input wire logic rc_tick,
  input wire logic watchdog_timeout_reset,
  // core side
  input wire logic sleep_mode,
  input wire logic int_wake,
  input wire logic watchdog_clear_instr,
  input wire logic global_irq_disable,
  output logic core_reset,
  output logic [1:0] phase,
  output logic regs_init,
  output logic pc_load_zero,
  output logic pc_advance,
  output logic vector_fetch,
  output logic wake_resume,
  output logic timeout_flag_n,
  output logic powerdown_flag_n,
  output logic [1:0] status_upper,
  // external bus strobes
  output logic addr_latch_strobe,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic strobe_oe_n
);

  localparam logic [RTS_SETTLE_W-1:0] SETTLE_LOAD = RTS_SETTLE_W'(SETTLE_TICKS);
  localparam logic [RTS_OST_W-1:0] OST_LOAD = RTS_OST_W'(RTS_OST_CYCLES);

  rts_state_t s;
  rts_state_t next_s;

  logic por_s;
  logic master_clear_pin_s;
  logic osc_rise;
  logic ovalid_s;
  logic rc_rise;
  logic wdt_rise;
  logic crystal;
  logic supply_drop;
  logic bus_take;

  // ---------------------------------------------------------------
  // synchronised views (second and third stages only)
  // ---------------------------------------------------------------
  assign por_s = s.sync2[RTS_SY_POR];
  assign master_clear_pin_s = s.sync2[RTS_SY_MASTER_CLEAR_PIN];
  assign osc_rise = s.sync2[RTS_SY_OSC] & ~s.sync3[RTS_SY_OSC];
  assign ovalid_s = s.sync2[RTS_SY_OVALID];
  assign rc_rise = s.sync2[RTS_SY_RC] & ~s.sync3[RTS_SY_RC];
  assign wdt_rise = s.sync2[RTS_SY_WDT] & ~s.sync3[RTS_SY_WDT];
  assign crystal = (s.osc_mode == RTS_OSC_XT) || (s.osc_mode == RTS_OSC_LF);
  // legacy part ignores a falling supply once it has been up
  assign supply_drop = !por_s && (!LEGACY_VARIANT || !s.supply_seen);
  assign bus_take = (avs_read || avs_write) && !s.waitrequest;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.sync1 = {watchdog_timeout_reset, rc_tick, osc_valid, osc_input_pin,
                    master_clear_pin, supply_up_detect};
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    next_s.regs_init = 1'b0;
    next_s.pc_load_zero = 1'b0;
    next_s.pc_advance = 1'b0;
    next_s.vector_fetch = 1'b0;
    next_s.wake_resume = 1'b0;
    if (por_s) begin
      next_s.supply_seen = 1'b1;
    end

    // supply timer on rc ticks, oscillator counter on valid pulses
    if (s.rc_cnt != '0 && rc_rise) begin
      next_s.rc_cnt = s.rc_cnt - 1'b1;
    end
    if (s.osc_cnt != '0 && osc_rise && ovalid_s) begin
      next_s.osc_cnt = s.osc_cnt - 1'b1;
    end

    if (supply_drop && s.seq != SEQ_POR) begin
      next_s.seq = SEQ_POR;
      next_s.supply_seen = 1'b0;
      next_s.timeout_flag_n = 1'b1;
      next_s.powerdown_flag_n = 1'b1;
      next_s.status_upper = RTS_UPPER_RESET;
      next_s.regs_init = 1'b1;
      next_s.pc_load_zero = 1'b1;
    end else if (!master_clear_pin_s && s.seq != SEQ_POR && s.seq != SEQ_MASTER_CLEAR_PIN) begin
      // master-clear from run, sleep or a pending settle
      next_s.seq = SEQ_MASTER_CLEAR_PIN;
      next_s.ost_needed = sleep_mode && crystal;
      next_s.timeout_flag_n = 1'b1;
      next_s.powerdown_flag_n = !sleep_mode;
      next_s.status_upper = RTS_UPPER_RESET;
      next_s.regs_init = 1'b1;
      next_s.pc_load_zero = 1'b1;
    end else begin
      case (s.seq)
        SEQ_POR: begin
          if (por_s && master_clear_pin_s) begin
            // both timers start together on the first clear-high
            next_s.rc_cnt = SETTLE_LOAD;
            next_s.osc_cnt = crystal ? OST_LOAD : '0;
            next_s.seq = SEQ_SETTLE;
            next_s.timeout_flag_n = 1'b1;
            next_s.powerdown_flag_n = 1'b1;
            next_s.status_upper = RTS_UPPER_RESET;
          end
        end
        SEQ_SETTLE: begin
          if (s.rc_cnt == '0 && s.osc_cnt == '0) begin
            next_s.seq = SEQ_RUN;
          end
        end
        SEQ_RUN: begin
          if (wdt_rise) begin
            next_s.timeout_flag_n = 1'b0;
            next_s.powerdown_flag_n = !sleep_mode;
            next_s.status_upper = RTS_UPPER_RESET;
            next_s.regs_init = !sleep_mode;
            next_s.pc_load_zero = 1'b1;
            next_s.osc_cnt = (sleep_mode && crystal) ? OST_LOAD : '0;
            next_s.seq = SEQ_OSC_WAIT;
          end else if (sleep_mode && int_wake) begin
            next_s.timeout_flag_n = 1'b1;
            next_s.powerdown_flag_n = 1'b0;
            next_s.status_upper = global_irq_disable ? RTS_UPPER_RESET
                                                     : RTS_UPPER_WAKE_EN;
            next_s.osc_cnt = crystal ? OST_LOAD : '0;
            next_s.seq = SEQ_WAKE;
          end else if (watchdog_clear_instr) begin
            next_s.timeout_flag_n = 1'b1;
            next_s.powerdown_flag_n = 1'b1;
          end
        end
        SEQ_MASTER_CLEAR_PIN: begin
          if (master_clear_pin_s) begin
            next_s.osc_cnt = s.ost_needed ? OST_LOAD : '0;
            next_s.seq = s.ost_needed ? SEQ_OSC_WAIT : SEQ_RUN;
          end
        end
        SEQ_OSC_WAIT: begin
          if (s.osc_cnt == '0) begin
            next_s.seq = SEQ_RUN;
          end
        end
        SEQ_WAKE: begin
          if (s.osc_cnt == '0) begin
            next_s.seq = SEQ_RUN;
            next_s.wake_resume = 1'b1;
            next_s.pc_advance = 1'b1;
            next_s.vector_fetch = !global_irq_disable;
          end
        end
        default: begin
          next_s.seq = SEQ_POR;
        end
      endcase
    end

    // reset held in every state but run and wake
    next_s.core_reset = (next_s.seq != SEQ_RUN) && (next_s.seq != SEQ_WAKE);
    // phases restart from phase one at release
    if (s.core_reset || next_s.core_reset) begin
      next_s.phase = 2'h0;
    end else begin
      next_s.phase = s.phase + 2'h1;
    end
    next_s.addr_latch_strobe = 1'b0;
    next_s.read_strobe_n = 1'b1;
    next_s.write_strobe_n = 1'b1;

    // avalon slave: one wait cycle, then answer
    next_s.waitrequest = !((avs_read || avs_write) && s.waitrequest);
    if ((avs_read || avs_write) && s.waitrequest) begin
      if (avs_read && avs_address == RTS_OFS_CONFIG) begin
        next_s.readdata = {29'h0000_0000, s.ext_exec, s.osc_mode};
      end else if (avs_read && avs_address == RTS_OFS_STATUS) begin
        next_s.readdata = RTS_RDATA_IDLE;
        next_s.readdata[RTS_ST_TO_BIT] = s.timeout_flag_n;
        next_s.readdata[RTS_ST_PD_BIT] = s.powerdown_flag_n;
        next_s.readdata[RTS_ST_UPPER_LSB +: 2] = s.status_upper;
        next_s.readdata[RTS_ST_RESET_BIT] = s.core_reset;
        next_s.readdata[RTS_ST_PHASE_LSB +: 2] = s.phase;
        next_s.readdata[RTS_ST_SEEN_BIT] = s.supply_seen;
      end else if (avs_read && avs_address == RTS_OFS_KEEP) begin
        next_s.readdata = {24'h00_0000, s.keep_reg};
      end else begin
        next_s.readdata = RTS_RDATA_IDLE;
      end
    end
    if (bus_take && avs_write && avs_byteenable[0]) begin
      if (avs_address == RTS_OFS_CONFIG) begin
        next_s.osc_mode = avs_writedata[RTS_CFG_OSC_LSB +: 2];
        next_s.ext_exec = avs_writedata[RTS_CFG_EXT_BIT];
      end else if (avs_address == RTS_OFS_KEEP) begin
        // no device reset ever touches this register
        next_s.keep_reg = avs_writedata[7:0];
      end
    end
    next_s.strobe_oe_n = !(next_s.core_reset && next_s.ext_exec);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.seq <= SEQ_POR;
      s.core_reset <= 1'b1;
      s.read_strobe_n <= 1'b1;
      s.write_strobe_n <= 1'b1;
      s.strobe_oe_n <= 1'b1;
      s.timeout_flag_n <= 1'b1;
      s.powerdown_flag_n <= 1'b1;
      s.status_upper <= RTS_UPPER_RESET;
      s.osc_mode <= RTS_RST_OSC_MODE;
      s.waitrequest <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign avs_readdata = s.readdata;
  assign avs_waitrequest = s.waitrequest;
  assign core_reset = s.core_reset;
  assign phase = s.phase;
  assign regs_init = s.regs_init;
  assign pc_load_zero = s.pc_load_zero;
  assign pc_advance = s.pc_advance;
  assign vector_fetch = s.vector_fetch;
  assign wake_resume = s.wake_resume;
  assign timeout_flag_n = s.timeout_flag_n;
  assign powerdown_flag_n = s.powerdown_flag_n;
  assign status_upper = s.status_upper;
  assign addr_latch_strobe = s.addr_latch_strobe;
  assign read_strobe_n = s.read_strobe_n;
  assign write_strobe_n = s.write_strobe_n;
  assign strobe_oe_n = s.strobe_oe_n;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic stay;
  assign stay = por_s && master_clear_pin_s;

  sequence q_wdt_run;
    s.seq == SEQ_RUN && stay && wdt_rise;
  endsequence

  sequence q_wake_done;
    s.seq == SEQ_WAKE && stay && s.osc_cnt == '0;
  endsequence

  property p_phase_hold;
    @(posedge clock) disable iff (!arst_n)
      core_reset |-> phase == 2'h0 ##1 (core_reset || phase == 2'h0);
  endproperty
  a_phase_hold: assert property (p_phase_hold) else $error("phase ran during reset");

  property p_strobes;
    @(posedge clock) disable iff (!arst_n)
      (core_reset && s.ext_exec && $past(core_reset)) |->
        !strobe_oe_n && !addr_latch_strobe && read_strobe_n && write_strobe_n;
  endproperty
  a_strobes: assert property (p_strobes) else $error("strobes not forced in reset");

  property p_supply_low;
    @(posedge clock) disable iff (!arst_n)
      (!por_s && !s.supply_seen) |=> core_reset;
  endproperty
  a_supply_low: assert property (p_supply_low) else $error("left reset with supply low");

  property p_supply_fall;
    @(posedge clock) disable iff (!arst_n)
      (!LEGACY_VARIANT && s.seq == SEQ_RUN && !por_s) |=> s.seq == SEQ_POR && core_reset;
  endproperty
  a_supply_fall: assert property (p_supply_fall) else $error("supply fall missed");

  property p_settle_start;
    @(posedge clock) disable iff (!arst_n)
      (s.seq == SEQ_POR && stay) |=>
        s.rc_cnt == SETTLE_LOAD && s.osc_cnt == ($past(crystal) ? OST_LOAD : '0);
  endproperty
  a_settle_start: assert property (p_settle_start) else $error("timers not loaded");

  property p_settle_hold;
    @(posedge clock) disable iff (!arst_n)
      (s.seq == SEQ_SETTLE && (s.rc_cnt != '0 || s.osc_cnt != '0)) |=> core_reset;
  endproperty
  a_settle_hold: assert property (p_settle_hold) else $error("released while settling");

  property p_master_clear_pin_quick;
    @(posedge clock) disable iff (!arst_n)
      (s.seq == SEQ_MASTER_CLEAR_PIN && stay && !s.ost_needed) |=> !core_reset ##1 phase == 2'h1;
  endproperty
  a_master_clear_pin_quick: assert property (p_master_clear_pin_quick) else $error("master-clear got delay");

  property p_wdt_normal;
    @(posedge clock) disable iff (!arst_n)
      (q_wdt_run and (##0 !sleep_mode)) |=>
        !timeout_flag_n && powerdown_flag_n && regs_init && pc_load_zero;
  endproperty
  a_wdt_normal: assert property (p_wdt_normal) else $error("normal watchdog reset wrong");

  property p_wdt_sleep;
    @(posedge clock) disable iff (!arst_n)
      (q_wdt_run and (##0 sleep_mode)) |=>
        !timeout_flag_n && !powerdown_flag_n && !regs_init && pc_load_zero;
  endproperty
  a_wdt_sleep: assert property (p_wdt_sleep) else $error("sleep watchdog reset wrong");

  property p_wake;
    @(posedge clock) disable iff (!arst_n)
      q_wake_done |=> pc_advance && wake_resume && !pc_load_zero &&
        vector_fetch == !$past(global_irq_disable);
  endproperty
  a_wake: assert property (p_wake) else $error("wake resume wrong");

endmodule

`default_nettype wire

// file: test/rts_sequencer_tb.sv
// self-checking bench for the reset time-out sequencer
`timescale 1ns/1ns
`default_nettype none

module rts_sequencer_tb;
  import rts_pkg::*;
  localparam int TICKS = 4;
  logic clock, arst_n, avs_read, avs_write, avs_waitrequest, osc_run;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q, rnd, seed;
  logic supply_up_detect, master_clear_pin, osc_input_pin, osc_valid, rc_tick;
  logic watchdog_timeout_reset, sleep_mode, int_wake, watchdog_clear_instr;
  logic global_irq_disable, core_reset, regs_init, pc_load_zero, pc_advance;
  logic vector_fetch, wake_resume, timeout_flag_n, powerdown_flag_n;
  logic addr_latch_strobe, read_strobe_n, write_strobe_n, strobe_oe_n, prev_cr;
  logic [1:0] phase, status_upper;
  int errors, n_compared, n_ri, n_pcz, n_pa, n_vf, n_wr, n_cr, n_osc, n_rc;

  rts_sequencer #(.SETTLE_TICKS(TICKS)) dut_u (
    .clock, .arst_n, .avs_address, .avs_read, .avs_write, .avs_byteenable,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .supply_up_detect,
    .master_clear_pin, .osc_input_pin, .osc_valid, .rc_tick, .watchdog_timeout_reset,
    .sleep_mode, .int_wake, .watchdog_clear_instr, .global_irq_disable, .core_reset,
    .phase, .regs_init, .pc_load_zero, .pc_advance, .vector_fetch, .wake_resume,
    .timeout_flag_n, .powerdown_flag_n, .status_upper, .addr_latch_strobe,
    .read_strobe_n, .write_strobe_n, .strobe_oe_n
  );

  rts_xtal_model xtal_u (
    .clock, .osc_run, .osc_input_pin, .osc_valid, .rc_tick
  );

  always #25 clock = ~clock;

  // --------------------------------------------------------------
  // monitors
  // --------------------------------------------------------------
  always @(posedge clock) begin
    n_ri += (regs_init === 1'b1);
    n_pcz += (pc_load_zero === 1'b1);
    n_pa += (pc_advance === 1'b1);
    n_vf += (vector_fetch === 1'b1);
    n_wr += (wake_resume === 1'b1);
    n_cr += (core_reset === 1'b1);
    if (prev_cr === 1'b1 && core_reset === 1'b1) begin
      chk_bit(phase === 2'h0, 1'b1);
    end
    prev_cr <= core_reset;
  end
  always @(posedge rc_tick) n_rc++;
  always @(posedge osc_input_pin) n_osc += (osc_valid === 1'b1);

  // --------------------------------------------------------------
  // compare, expectation and driver tasks
  // --------------------------------------------------------------
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  function automatic logic [1:0] exp_flags(input logic wdt, input logic sl);
    return {~wdt, ~sl};
  endfunction

  function automatic logic [1:0] exp_upper(input logic g);
    return g ? 2'h3 : 2'h2;
  endfunction

  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
           input logic [3:0] be);
    int k;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata;
    chk_bit(avs_waitrequest, 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask

  task wait_core(input logic v, input int lim);
    int k;
    k = 0;
    while (core_reset !== v && k < lim) begin
      @(posedge clock);
      k++;
    end
    chk_bit(core_reset, v);
  endtask

  task clr;
    n_ri = 0;
    n_pcz = 0;
    n_pa = 0;
    n_vf = 0;
    n_wr = 0;
    n_cr = 0;
    n_osc = 0;
    n_rc = 0;
  endtask

  task reset_ev(input logic wdt, input logic sl);
    sleep_mode <= sl;
    osc_run <= wdt & sl;
    clr();
    if (wdt) begin
      watchdog_timeout_reset <= 1'b1;
    end else begin
      master_clear_pin <= 1'b0;
    end
    wait_core(1'b1, 12);
    repeat (6) @(posedge clock);
    watchdog_timeout_reset <= 1'b0;
    if (!wdt) begin
      chk_bit(phase === 2'h0, 1'b1);
      chk_word({addr_latch_strobe, read_strobe_n, write_strobe_n, strobe_oe_n}, 4'h6);
      n_osc = 0;
      master_clear_pin <= 1'b1;
      osc_run <= sl;
    end
    wait_core(1'b0, sl ? 6000 : 12);
    chk_word({timeout_flag_n, powerdown_flag_n}, exp_flags(wdt, sl));
    chk_word(n_pcz, 1);
    chk_word(n_ri, (wdt && sl) ? 0 : 1);
    if (sl) begin
      chk_bit(n_osc >= 1024, 1'b1);
    end
    sleep_mode <= 1'b0;
    osc_run <= 1'b0;
    repeat (($unsigned($random(seed)) % 8) + 1) @(posedge clock);
  endtask

  task wake(input logic g, input logic xt);
    int k;
    global_irq_disable <= g;
    sleep_mode <= 1'b1;
    clr();
    @(posedge clock);
    int_wake <= 1'b1;
    osc_run <= 1'b1;
    @(posedge clock);
    int_wake <= 1'b0;
    k = 0;
    while (n_wr == 0 && k < 6000) begin
      @(posedge clock);
      k++;
    end
    chk_word(n_wr, 1);
    chk_bit(n_osc >= 1024, xt);
    chk_word({timeout_flag_n, powerdown_flag_n}, 2'h2);
    chk_word(status_upper, exp_upper(g));
    chk_word({n_pa[7:0], n_vf[7:0], n_pcz[7:0]}, {8'h1, 7'h0, ~g, 8'h0});
    chk_word(n_cr, 0);
    sleep_mode <= 1'b0;
    osc_run <= 1'b0;
    @(posedge clock);
  endtask

  task test_done;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    seed = 32'h4e82;
    clock = 1'b0;
    arst_n = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'h0;
    avs_writedata = 32'h0000_0000;
    supply_up_detect = 1'b0;
    master_clear_pin = 1'b1;
    watchdog_timeout_reset = 1'b0;
    sleep_mode = 1'b0;
    int_wake = 1'b0;
    watchdog_clear_instr = 1'b0;
    global_irq_disable = 1'b0;
    osc_run = 1'b0;
    prev_cr = 1'b0;
    errors = 0;
    n_compared = 0;
    clr();
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    bus(1'b0, RTS_OFS_CONFIG, 32'h0000_0000, 4'h1);
    chk_word(q, 32'h0000_0001);
    bus(1'b0, RTS_OFS_STATUS, 32'h0000_0000, 4'h1);
    chk_word(q, 32'h0000_001f);
    bus(1'b0, 4'hc, 32'h0000_0000, 4'h1);
    chk_word(q, 32'h0000_0000);
    rnd = $random(seed);
    bus(1'b1, RTS_OFS_KEEP, rnd, 4'h1);
    bus(1'b1, RTS_OFS_KEEP, ~rnd, 4'h0);
    bus(1'b0, RTS_OFS_KEEP, 32'h0000_0000, 4'h1);
    chk_word(q, {24'h0, rnd[7:0]});
    bus(1'b1, RTS_OFS_CONFIG, {29'h0, 1'b1, RTS_OSC_EC}, 4'h1);
    repeat (30) @(posedge clock);
    chk_bit(core_reset, 1'b1);
    clr();
    osc_run <= 1'b1;
    supply_up_detect <= 1'b1;
    wait_core(1'b0, 400);
    chk_bit(n_rc >= TICKS, 1'b1);
    chk_word(n_osc, 0);
    chk_word({timeout_flag_n, powerdown_flag_n}, 2'h3);
    for (int i = 0; i < 4; i++) begin
      chk_word(phase, i[1:0]);
      @(posedge clock);
    end
    bus(1'b1, RTS_OFS_CONFIG, {29'h0, 1'b1, RTS_OSC_XT}, 4'h1);
    reset_ev(1'b0, 1'b0);
    reset_ev(1'b1, 1'b0);
    watchdog_clear_instr <= 1'b1;
    @(posedge clock);
    watchdog_clear_instr <= 1'b0;
    repeat (3) @(posedge clock);
    chk_word({timeout_flag_n, powerdown_flag_n}, 2'h3);
    reset_ev(1'b0, 1'b1);
    reset_ev(1'b1, 1'b1);
    wake(1'b1, 1'b1);
    bus(1'b1, RTS_OFS_CONFIG, {29'h0, 1'b1, RTS_OSC_RC}, 4'h1);
    wake(1'b0, 1'b0);
    bus(1'b1, RTS_OFS_CONFIG, {29'h0, 1'b1, RTS_OSC_LF}, 4'h1);
    supply_up_detect <= 1'b0;
    wait_core(1'b1, 8);
    repeat (20) @(posedge clock);
    chk_bit(core_reset, 1'b1);
    clr();
    osc_run <= 1'b1;
    supply_up_detect <= 1'b1;
    wait_core(1'b0, 6000);
    chk_bit(n_osc >= 1024 && n_rc >= TICKS, 1'b1);
    bus(1'b0, RTS_OFS_KEEP, 32'h0000_0000, 4'h1);
    chk_word(q, {24'h0, rnd[7:0]});
    test_done();
  end

  initial begin
    #2_000_000;
    errors++;
    test_done();
  end
endmodule

`default_nettype wire

// file: test/rts_xtal_model.sv
// crystal oscillator and internal rc tick model for the sequencer bench
`timescale 1ns/1ns
`default_nettype none

module rts_xtal_model (
  // clock and control
  input wire logic clock,
  input wire logic osc_run,
  // oscillator and rc outputs
  output logic osc_input_pin,
  output logic osc_valid,
  output logic rc_tick
);
  logic [1:0] div = 2'h0;
  logic [4:0] amp = 5'h00;
  logic [2:0] rc_div = 3'h0;

  // rc runs free; crystal stands still while stopped
  always @(posedge clock) begin
    rc_div <= rc_div + 3'h1;
    rc_tick <= rc_div[2];
    if (!osc_run) begin
      div <= 2'h0;
      amp <= 5'h00;
      osc_input_pin <= 1'b0;
      osc_valid <= 1'b0;
    end else begin
      div <= div + 2'h1;
      osc_input_pin <= div[1];
      if (div == 2'h3 && amp != 5'h1f) begin
        amp <= amp + 5'h01;
      end
      // amplitude builds up over the first sixteen pulses
      osc_valid <= (amp >= 5'h10);
    end
  end
endmodule

`default_nettype wire
